// ==== cscp_pkg.sv ====
package cscp_pkg;

  // pixel bus width and synchroniser depth
  localparam int unsigned PIX_W       = 8;
  localparam int unsigned SYNC_STAGES = 2;

  // system clock and the frame-to-line spacing owed by the sensor
  localparam int unsigned SYS_CLK_HZ        = 50_000_000;
  localparam int unsigned SYS_PERIOD_NS     = 1_000_000_000 / SYS_CLK_HZ;
  localparam int unsigned FRAME_GAP_PERIODS = 9;
  localparam int unsigned FRAME_GAP_NS      = FRAME_GAP_PERIODS * SYS_PERIOD_NS;
  // least time: round up to whole cycles, never below one
  localparam int unsigned FRAME_GAP_RAW     = (FRAME_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned FRAME_GAP_CYCLES  = (FRAME_GAP_RAW < 1) ? 1 : FRAME_GAP_RAW;
  localparam int unsigned GAP_CNT_W         = $clog2(FRAME_GAP_CYCLES + 1);
  localparam logic [GAP_CNT_W-1:0] GAP_CNT_RST  = '0;
  localparam logic [GAP_CNT_W-1:0] GAP_CNT_LAST = GAP_CNT_W'(FRAME_GAP_CYCLES);

  // reset values
  localparam logic [PIX_W-1:0] PIX_RST = '0;

  // one captured pixel with its position markers
  typedef struct packed {
    logic             frame_first;
    logic             line_first;
    logic [PIX_W-1:0] data;
  } cscp_pixel_t;

  // the raw sensor pins, grouped so they cross the synchroniser together
  typedef struct packed {
    logic             frame_sync;
    logic             line_sync;
    logic             sample_clk;
    logic [PIX_W-1:0] data;
  } cscp_pins_t;

  localparam int unsigned PINS_W = $bits(cscp_pins_t);

endpackage : cscp_pkg

// ==== cscp_sync.sv ====
`timescale 1ns/1ps
module cscp_sync
  import cscp_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // per bit a plain shift chain; only the last stage is visible outside
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic [SYNC_STAGES-1:0] chain;
      always_ff @(posedge i_sys_clk)
      begin
        if (!i_rst_b)
          chain <= '0;
        else
          chain <= {chain[SYNC_STAGES-2:0], i_async[g]};
      end
      assign o_sync[g] = chain[SYNC_STAGES-1];
    end
  endgenerate

endmodule : cscp_sync

// ==== cscp_capture.sv ====
`timescale 1ns/1ps
// Operation
// RL1 - In gated mode the frame sync, line sync and sample clock together decide when a pixel is captured.
// RL2 - A frame starts on the chosen edge of the frame sync, and in gated mode the line sync stays high for a line.
// RL3 - In gated mode sample clock edges count, and pixels are taken, only while the line sync is high.
// RL4 - For a sensor that launches data on the falling sample clock edge, the pixel bus is taken on the rising edge.
// RL5 - For a sensor that launches data on the rising sample clock edge, the pixel bus is taken on the falling edge.
// RL6 - In non-gated mode only the frame sync and the sample clock are used and the line sync is ignored.
// RL7 - In gated mode the sensor leaves at least nine system clock periods from the frame edge to the line rise.
// RL8 - In non-gated mode the sensor leaves at least nine system clock periods from the frame edge to the first pixel.
// RL9 - The sample clock runs at no more than half the system clock, and may be slower or stopped.
// RL10 - Each high and each low phase of the sample clock lasts at least one system clock period.
// RL11 - The sample clock and both syncs are synchronised into the system clock and their edges found there.
module cscp_capture
  import cscp_pkg::*;
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_gated_mode,
  input  wire logic             i_frame_on_rise,
  input  wire logic             i_sensor_launch_rise,
  input  wire logic             i_frame_sync,
  input  wire logic             i_line_sync,
  input  wire logic             i_sample_clk,
  input  wire logic [PIX_W-1:0] i_pix_data,
  output cscp_pixel_t           o_pixel,
  output logic                  o_pixel_valid,
  output logic                  o_frame_start,
  output logic                  o_frame_active,
  output logic                  o_line_active,
  output logic                  o_gap_short
);

  cscp_pins_t pins_raw;
  cscp_pins_t pins_s;
  cscp_pins_t pins_prev;
  logic       frame_edge;
  logic       line_rise;
  logic       clk_rise;
  logic       clk_fall;
  logic       latch_edge;
  logic       line_ok;
  logic       take;
  logic       frame_seen;
  logic       first_in_frame;
  logic       first_in_line;
  logic       gap_running;
  logic [GAP_CNT_W-1:0] gap_cnt;
  logic [GAP_CNT_W-1:0] next_gap_cnt;
  logic                 warm_ok;
  logic [SYNC_STAGES:0] warm;

  // data crosses with the syncs so both carry the same latency
  assign pins_raw.frame_sync = i_frame_sync;
  assign pins_raw.line_sync  = i_line_sync;
  assign pins_raw.sample_clk = i_sample_clk;
  assign pins_raw.data       = i_pix_data;

  // two-stage crossing of every sensor pin
  cscp_sync #(
    .WIDTH (PINS_W)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_async   (pins_raw),
    .o_sync    (pins_s)
  ); // RL11

  // one more stage of history for edge detection, taken after the crossing
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      pins_prev <= '0;
    else
      pins_prev <= pins_s;
  end

  // edges are ignored until the crossing and the history stage hold real pin
  // levels; a pin idling high would otherwise look like a rise after reset,
  // so a level already standing at reset release is never taken as an edge
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      warm <= '0;
    else
      warm <= {warm[SYNC_STAGES-1:0], 1'b1};
  end

  assign warm_ok = warm[SYNC_STAGES]; // RL11

  // edges found in the system clock domain; each sample clock phase spans
  // at least one system period, so no edge slips between two samples
  assign clk_rise   = warm_ok & pins_s.sample_clk & ~pins_prev.sample_clk;  // RL11
  assign clk_fall   = warm_ok & ~pins_s.sample_clk & pins_prev.sample_clk;  // RL11
  assign line_rise  = warm_ok & pins_s.line_sync & ~pins_prev.line_sync;    // RL11
  assign frame_edge = warm_ok & (i_frame_on_rise ? (pins_s.frame_sync & ~pins_prev.frame_sync)
                                                 : (~pins_s.frame_sync & pins_prev.frame_sync)); // RL2

  // latch on the edge opposite to the one that launches data
  assign latch_edge = i_sensor_launch_rise ? clk_fall  // RL5
                                           : clk_rise; // RL4

  // gated mode qualifies with the line sync, non-gated ignores it
  assign line_ok = i_gated_mode ? pins_s.line_sync // RL3
                                : 1'b1;            // RL6

  // a pixel is taken only inside a frame, on the latch edge, and in gated mode inside a line
  assign take = frame_seen & latch_edge & line_ok; // RL1

  // frame tracking: a new frame restarts on every selected frame edge
  // no end of frame is tracked; a stopped sensor leaves the frame flag up
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      frame_seen     <= 1'b0;
      first_in_frame <= 1'b0;
    end
    else if (frame_edge)
    begin
      frame_seen     <= 1'b1; // RL2
      first_in_frame <= 1'b1;
    end
    else if (take)
      first_in_frame <= 1'b0;
  end

  // line start marker; in non-gated mode lines are not delimited at all
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      first_in_line <= 1'b0;
    else if (frame_edge || (i_gated_mode && line_rise))
      first_in_line <= 1'b1; // RL2
    else if (take)
      first_in_line <= 1'b0;
  end

  // pixel output register, data held between captures
  // o_pixel_valid follows the latch edge on the pin by two to three system
  // clocks: two crossing stages and this register, the first stage taking the sampling phase
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      o_pixel       <= '{frame_first: 1'b0, line_first: 1'b0, data: PIX_RST};
      o_pixel_valid <= 1'b0;
    end
    else
    begin
      o_pixel_valid <= take; // RL1
      if (take)
      begin
        o_pixel.data        <= pins_s.data; // RL4 RL5
        o_pixel.frame_first <= first_in_frame;
        o_pixel.line_first  <= first_in_line & i_gated_mode;
      end
    end
  end

  // status flags for the surrounding logic
  // o_line_active ignores the line sync in non-gated mode, just as capture does
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      o_frame_start  <= 1'b0;
      o_frame_active <= 1'b0;
      o_line_active  <= 1'b0;
    end
    else
    begin
      o_frame_start  <= frame_edge;
      o_frame_active <= frame_seen | frame_edge;
      o_line_active  <= (frame_seen | frame_edge) & line_ok;
    end
  end

  // spacing watch: counts system cycles after a frame edge; the sensor owes
  // nine periods before the line rise (gated) or the first pixel (non-gated).
  // a breach is only reported, capture goes on, since the data may still be good
  // the count starts at one: the cycle that finds the frame edge is already
  // the first owed period, so exactly nine periods reads as nine, not eight
  always_comb
  begin
    next_gap_cnt = gap_cnt;
    if (frame_edge)
      next_gap_cnt = GAP_CNT_RST + GAP_CNT_W'(1);
    else if (gap_running && gap_cnt != GAP_CNT_LAST)
      next_gap_cnt = gap_cnt + GAP_CNT_W'(1);
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      gap_cnt     <= GAP_CNT_RST;
      gap_running <= 1'b0;
    end
    else
    begin
      gap_cnt <= next_gap_cnt;
      if (frame_edge)
        gap_running <= 1'b1;
      else if (gap_cnt == GAP_CNT_LAST || (i_gated_mode ? line_rise : latch_edge))
        gap_running <= 1'b0;
    end
  end

  // one-cycle pulse when the owed spacing was not kept
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      o_gap_short <= 1'b0;
    else
      o_gap_short <= gap_running && !frame_edge && (gap_cnt < GAP_CNT_LAST)
                     && (i_gated_mode ? line_rise   // RL7
                                      : latch_edge); // RL8
  end

endmodule : cscp_capture

// ==== cscp_capture_props.sv ====
`timescale 1ns/1ps
module cscp_capture_props
  import cscp_pkg::*;
(
  input wire logic             i_sys_clk,
  input wire logic             i_rst_b,
  input wire logic             i_gated_mode,
  input wire logic             i_frame_on_rise,
  input wire logic             i_sensor_launch_rise,
  input wire logic             i_frame_sync,
  input wire logic             i_line_sync,
  input wire logic             i_sample_clk,
  input wire logic [PIX_W-1:0] i_pix_data,
  input wire cscp_pixel_t      o_pixel,
  input wire logic             o_pixel_valid,
  input wire logic             o_frame_start,
  input wire logic             o_frame_active,
  input wire logic             o_line_active,
  input wire logic             o_gap_short
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // pin edges reach the outputs through a two-flop synchroniser
  frame_edge_a:
    assert property ((i_frame_on_rise ? $rose(i_frame_sync) : $fell(i_frame_sync)) |-> ##[1:4] o_frame_start)
    else $error("selected frame edge gave no frame start");
  frame_other_a:
    assert property ((i_frame_on_rise ? $fell(i_frame_sync) : $rose(i_frame_sync)) |-> ##1 !o_frame_start [*4])
    else $error("unselected frame edge gave a frame start");
  latch_edge_a:
    assert property ((i_sensor_launch_rise ? $fell(i_sample_clk) : $rose(i_sample_clk)) && o_line_active
                     |-> ##[1:4] o_pixel_valid) else $error("latch edge gave no pixel");
  launch_edge_a:
    assert property ((i_sensor_launch_rise ? $rose(i_sample_clk) : $fell(i_sample_clk)) |-> ##1 !o_pixel_valid [*3])
    else $error("launch edge gave a pixel");
  in_frame_a:
    assert property (o_pixel_valid |-> o_frame_active) else $error("pixel outside a frame");
  gated_line_a:
    assert property (o_pixel_valid && i_gated_mode |-> o_line_active || $past(o_line_active))
    else $error("gated pixel with line low");
  ungated_a:
    assert property (!i_gated_mode && $past(o_frame_active) |-> o_line_active && !o_pixel.line_first)
    else $error("line sync not ignored");
  pixel_data_a:
    assert property (o_pixel_valid |-> o_pixel.data == $past(i_pix_data, 3)) else $error("pixel data wrong");
endmodule : cscp_capture_props
bind cscp_capture cscp_capture_props cscp_capture_props_inst (.*);

// ==== cscp_sensor_model.sv ====
`timescale 1ns/1ps
module cscp_sensor_model
  import cscp_pkg::*;
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_launch_rise,
  output logic                  o_frame_sync = 1'b0,
  output logic                  o_line_sync = 1'b0,
  output logic                  o_sample_clk = 1'b0,
  output logic      [PIX_W-1:0] o_pix_data = '0
);
  // idle: clock parked at its latch level, so it stands still outside frames
  task automatic park(input logic fl);
    o_frame_sync <= fl;
    o_line_sync  <= 1'b0;
    o_sample_clk <= ~i_launch_rise;
  endtask : park
  // frame edge, then the given gap in system periods before any line or pixel
  task automatic frame(input logic lvl, input int gap);
    o_frame_sync <= lvl;
    repeat (gap) @(posedge i_sys_clk);
  endtask : frame
  // released bus shows the inverse so a stale value never matches
  task automatic line(input logic lvl);
    o_line_sync <= lvl;
    if (!lvl)
      o_pix_data <= ~o_pix_data;
    repeat (12) @(posedge i_sys_clk);
  endtask : line
  // data changes on the launch edge, held four cycles each side of the latch
  task automatic pix(input logic [PIX_W-1:0] d);
    o_sample_clk <= i_launch_rise;
    o_pix_data   <= d;
    repeat (4) @(posedge i_sys_clk);
    o_sample_clk <= ~i_launch_rise;
    repeat (4) @(posedge i_sys_clk);
  endtask : pix
endmodule : cscp_sensor_model

// ==== cscp_capture_test.sv ====
`timescale 1ns/1ps
module cscp_capture_test;
  import cscp_pkg::*;
  logic             i_sys_clk = 0, i_rst_b = 0, gated = 0, frame_rise = 0, launch_rise = 0;
  logic             fs, ls, pc, valid, gap_short;
  int               gap_seen = 0;
  logic [PIX_W-1:0] pd;
  cscp_pixel_t      o_pixel;
  cscp_pixel_t      expq[$];
  int               num_errors = 0, compares = 0, cycles = 0, seed = 32'h18de;
  always #10 i_sys_clk = ~i_sys_clk;
  cscp_sensor_model sensor_inst (.i_sys_clk(i_sys_clk), .i_launch_rise(launch_rise), .o_frame_sync(fs),
                                 .o_line_sync(ls), .o_sample_clk(pc), .o_pix_data(pd));
  cscp_capture cscp_capture_inst (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_gated_mode(gated),
    .i_frame_on_rise(frame_rise), .i_sensor_launch_rise(launch_rise), .i_frame_sync(fs), .i_line_sync(ls),
    .i_sample_clk(pc), .i_pix_data(pd), .o_pixel(o_pixel), .o_pixel_valid(valid), .o_frame_start(),
    .o_frame_active(), .o_line_active(), .o_gap_short(gap_short));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input cscp_pixel_t exp, input cscp_pixel_t got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // a random pixel; noted only when the block should take it
  task automatic pixel(input logic f, input logic l, input logic take);
    logic [PIX_W-1:0] d;
    d = PIX_W'($random(seed));
    if (take)
      expq.push_back({f, l, d});
    sensor_inst.pix(d);
  endtask : pixel
  // watcher: sampled off the edge so registered outputs have settled
  always @(negedge i_sys_clk)
  begin
    if (i_rst_b && valid === 1'b1)
      check("pixel", (expq.size() > 0) ? expq.pop_front() : 'x, o_pixel);
    if (i_rst_b && gap_short === 1'b1)
      gap_seen++;
  end
  // reset with the sensor parked; the first frame edge waits until the
  // crossing holds the idle pin levels, so it is never swallowed at release
  task automatic restart();
    i_rst_b <= 1'b0;
    @(posedge i_sys_clk);
    sensor_inst.park(~frame_rise);
    repeat (3) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    gap_seen = 0;
  endtask : restart
  // end of a mode: no pixel still owed, and the spacing flag seen as often as due
  task automatic mode_end(input int m, input int gaps);
    compares += 2;
    if (expq.size() != 0)
    begin
      num_errors++;
      $display("CHECK FAILED pixels left expected 0 seen %0d", expq.size());
    end
    if (gap_seen != gaps)
    begin
      num_errors++;
      $display("CHECK FAILED gap flag expected %0d seen %0d", gaps, gap_seen);
    end
    expq.delete();
    $display("mode %0d done", m);
  endtask : mode_end
  // hang guard, well above the ~1100 cycles the run needs
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  // every mode, frame polarity and latch edge combination
  initial
  begin
    for (int m = 0; m < 8; m++)
    begin
      {gated, frame_rise, launch_rise} <= 3'(m);
      restart();
      sensor_inst.frame(frame_rise, 9);
      for (int ln = 0; ln < 2; ln++)
      begin
        if (gated)
          sensor_inst.line(1'b1);
        for (int p = 0; p < 3; p++)
          pixel(ln == 0 && p == 0, gated && p == 0, 1'b1);
        sensor_inst.line(1'b0);
        pixel(1'b0, 1'b0, !gated);
      end
      sensor_inst.frame(~frame_rise, 12);
      mode_end(m, 0);
    end
    // sensor breaks the owed spacing: the non-gated run still captures its pixel, the gated run drives none, the flag pulses once
    for (int m = 0; m < 2; m++)
    begin
      {gated, frame_rise, launch_rise} <= 3'(m * 6);
      restart();
      sensor_inst.frame(frame_rise, 2);
      if (gated)
        sensor_inst.line(1'b1);
      else
        pixel(1'b1, 1'b0, 1'b1);
      sensor_inst.frame(~frame_rise, 12);
      mode_end(8 + m, 1);
    end
    print_verdict();
  end
endmodule : cscp_capture_test
